// *** hdl/cfg_bank.sv ***
// customer configuration register bank with the control it steers
`timescale 1ns/1ns
module cfg_bank #(
  parameter logic [7:0] RST_IFACE_P = cfg_bank_pkg::RST_IFACE,
  parameter logic [7:0] RST_HOSTPIN_P = cfg_bank_pkg::RST_ZERO,
  parameter logic [7:0] RST_RSTIRQ_P = cfg_bank_pkg::RST_ZERO,
  parameter logic [7:0] RST_BUCKAUTO_P = cfg_bank_pkg::RST_ZERO,
  parameter logic [7:0] RST_LINAUTO_P = cfg_bank_pkg::RST_ZERO,
  parameter logic [7:0] RST_SDPOL_P = cfg_bank_pkg::RST_ZERO,
  parameter logic [7:0] RST_RSTTIM_P = cfg_bank_pkg::RST_ZERO,
  parameter int OC_OFF_CYC_P = cfg_bank_pkg::OC_OFF_CYC,
  parameter int BUS_TO_CYC_P = cfg_bank_pkg::BUS_TO_CYC,
  parameter int CYC_PER_MS_P = cfg_bank_pkg::CYC_PER_MS
) (
  input wire logic i_ref_clk, // core clock
  input wire logic i_srst, // sync reset, high
  input wire logic i_wr_en, // register write strobe
  input wire logic [8:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  output logic [7:0] o_rdata, // read data
  input wire logic i_application_lock_fuse, // lock fused
  input wire logic [6:0] i_bus_addr, // address seen on serial bus
  output logic o_addr_match, // address is ours
  output logic o_serial_high_speed_hold, // stay in high speed
  output logic o_serial_fast_plus_sel, // fast-mode-plus timing
  input wire logic i_irq_req, // internal interrupt level
  input wire logic i_low_power_down_state, // in power-down
  output logic o_interrupt_out_pin_o, // irq pin level
  output logic o_interrupt_out_pin_oe_n, // irq pin enable, low drives
  input wire logic i_seq_reset_req, // sequencer asks reset
  output logic o_system_reset_out_pin_o, // reset pin level (low active)
  output logic o_system_reset_out_pin_oe_n, // reset pin enable, low drives
  input wire logic i_second_nvm_read_phase, // second load phase
  output logic o_sysen_load_en, // allow system-enable load
  input wire logic i_power_up, // power-up event pulse
  output logic [2:0] o_buck_en, // bucks 1..3 enable
  output logic [2:0] o_buck_sel_a, // bucks select A
  output logic [3:0] o_linreg_en, // linear regs enable
  output logic [3:0] o_linreg_sel_a, // linear regs select A
  input wire logic [3:0] i_linreg_oc, // overcurrent pins, async
  input wire logic i_fault_off, // internal fault shutdown pulse
  input wire logic i_host_off, // host power-off pulse
  input wire logic i_host_reset_request_pin, // request pin, low active, async
  input wire logic i_key_off, // key shutdown pulse
  input wire logic i_key_long, // long press pulse
  input wire logic i_wdt_timeout, // watchdog pulse
  output logic o_shutdown, // shutdown pulse
  output logic o_fast_off, // skip sequencer slots
  output logic o_por_after, // power-on reset follows
  output logic o_power_down, // power-down pulse
  output logic o_serial_reset, // reset serial logic
  input wire logic i_bus_busy, // transfer in progress
  input wire logic i_bus_activity, // bus edge seen
  output logic o_bus_abort, // abandon transfer pulse
  input wire logic i_reset_mode, // sequencer in reset mode
  output logic o_reset_min_done, // minimum reset time elapsed
  output logic [1:0] o_key_lock_thr, // locking threshold code
  output logic [2:0] o_key_off_delay // threshold plus shut delay
);
  import cfg_bank_pkg::*;

  logic [7:0] iface_q, hostpin_q, faultlvl_q, buckclk_q, rstirq_q;
  logic [7:0] buckauto_q, linauto_q, buckcur_q, sdpol_q, rsttim_q;
  logic [2:0] rreq_sync_q;
  logic rreq_q;
  logic [3:0] oc_s1_q, oc_s2_q, oc_s3_q, oc_q;
  logic [31:0] oc_cnt_q [4];
  logic [31:0] to_cnt_q;
  logic [31:0] rst_cnt_q;
  logic [31:0] rst_need;

  function automatic logic [31:0] ms_to_cyc(input int ms);
    ms_to_cyc = 32'(ms * CYC_PER_MS_P);
  endfunction : ms_to_cyc

  // register writes; address field only while the part is unlocked
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      iface_q <= RST_IFACE_P;
      hostpin_q <= RST_HOSTPIN_P;
      faultlvl_q <= RST_ZERO;
      buckclk_q <= RST_ZERO;
      rstirq_q <= RST_RSTIRQ_P;
      buckauto_q <= RST_BUCKAUTO_P;
      linauto_q <= RST_LINAUTO_P;
      buckcur_q <= RST_ZERO;
      sdpol_q <= RST_SDPOL_P;
      rsttim_q <= RST_RSTTIM_P;
    end else if (i_wr_en) begin
      unique case (i_addr)
        ADDR_IFACE: if (!i_application_lock_fuse) iface_q <= i_wdata & MASK_IFACE;
        ADDR_HOSTPIN: hostpin_q <= i_wdata & MASK_HOSTPIN;
        ADDR_FAULTLVL: faultlvl_q <= i_wdata;
        ADDR_BUCKCLK: buckclk_q <= i_wdata;
        ADDR_RSTIRQ: rstirq_q <= i_wdata;
        ADDR_BUCKAUTO: buckauto_q <= i_wdata;
        ADDR_LINAUTO: linauto_q <= i_wdata;
        ADDR_BUCKCUR: buckcur_q <= i_wdata;
        ADDR_SDPOL: sdpol_q <= i_wdata;
        ADDR_RSTTIM: rsttim_q <= i_wdata;
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    unique case (i_addr)
      ADDR_IFACE: o_rdata = iface_q;
      ADDR_HOSTPIN: o_rdata = hostpin_q;
      ADDR_FAULTLVL: o_rdata = faultlvl_q;
      ADDR_BUCKCLK: o_rdata = buckclk_q;
      ADDR_RSTIRQ: o_rdata = rstirq_q;
      ADDR_BUCKAUTO: o_rdata = buckauto_q;
      ADDR_LINAUTO: o_rdata = linauto_q;
      ADDR_BUCKCUR: o_rdata = buckcur_q;
      ADDR_SDPOL: o_rdata = sdpol_q;
      ADDR_RSTTIM: o_rdata = rsttim_q;
      default: o_rdata = 8'h00;
    endcase
  end

  // target address: base nibble, low three bits zero or one
  assign o_addr_match = (i_bus_addr[6:3] == iface_q[7:4]) && (i_bus_addr[2:1] == 2'b00);
  assign o_serial_high_speed_hold = hostpin_q[BIT_HS_HOLD];
  assign o_serial_fast_plus_sel = hostpin_q[BIT_FAST_PLUS];

  // interrupt pin; in power-down only when allowed
  logic irq_act;
  assign irq_act = i_irq_req && (!i_low_power_down_state || rstirq_q[BIT_PD_IRQ]);
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_interrupt_out_pin_o <= 1'b1;
      o_interrupt_out_pin_oe_n <= 1'b0;
    end else begin
      o_interrupt_out_pin_o <= hostpin_q[BIT_IRQ_POL] ? irq_act : !irq_act;
      // open-drain only pulls low; high level released
      o_interrupt_out_pin_oe_n <= hostpin_q[BIT_OUT_TYPE] &&
        (hostpin_q[BIT_IRQ_POL] ? irq_act : !irq_act);
    end
  end

  // reset pin, forced while the force bit stands
  logic rst_act;
  assign rst_act = i_seq_reset_req || rstirq_q[BIT_FORCE_RST];
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_system_reset_out_pin_o <= 1'b0;
      o_system_reset_out_pin_oe_n <= 1'b0;
    end else begin
      o_system_reset_out_pin_o <= !rst_act;
      o_system_reset_out_pin_oe_n <= hostpin_q[BIT_OUT_TYPE] && !rst_act;
    end
  end

  assign o_sysen_load_en = !(i_second_nvm_read_phase && rstirq_q[BIT_SYSEN_SUPP]);

  // regulator enables: auto ones on power-up, overcurrent switches off
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_buck_en <= 3'h0;
      o_buck_sel_a <= 3'h0;
      o_linreg_en <= 4'h0;
      o_linreg_sel_a <= 4'h0;
    end else begin
      if (i_power_up) begin
        o_buck_en <= {buckauto_q[BIT_BUCK3], buckauto_q[BIT_BUCK2], buckauto_q[BIT_BUCK1]};
        o_buck_sel_a <= {buckauto_q[BIT_BUCK3], buckauto_q[BIT_BUCK2], buckauto_q[BIT_BUCK1]};
        o_linreg_en <= linauto_q[3:0];
        o_linreg_sel_a <= linauto_q[3:0];
      end
      for (int k = 0; k < 4; k++) begin
        if (sdpol_q[BIT_LIN_OC_OFF] && oc_cnt_q[k] >= 32'(OC_OFF_CYC_P)) o_linreg_en[k] <= 1'b0;
      end
      if (o_shutdown) begin
        o_buck_en <= 3'h0;
        o_linreg_en <= 4'h0;
      end
    end
  end

  // pin synchronisers: three stages, change taken when 2nd and 3rd agree
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      oc_s1_q <= 4'h0;
      oc_s2_q <= 4'h0;
      oc_s3_q <= 4'h0;
      oc_q <= 4'h0;
      rreq_sync_q <= 3'b111;
      rreq_q <= 1'b0;
    end else begin
      oc_s1_q <= i_linreg_oc;
      oc_s2_q <= oc_s1_q;
      oc_s3_q <= oc_s2_q;
      for (int k = 0; k < 4; k++) begin
        if (oc_s2_q[k] == oc_s3_q[k]) oc_q[k] <= oc_s3_q[k];
      end
      rreq_sync_q <= {rreq_sync_q[1:0], i_host_reset_request_pin};
      if (rreq_sync_q[1] == rreq_sync_q[2]) rreq_q <= !rreq_sync_q[2];
    end
  end

  // overcurrent persistence counters
  always_ff @(posedge i_ref_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (i_srst || !oc_q[k]) oc_cnt_q[k] <= 32'h0000_0000;
      else if (oc_cnt_q[k] < 32'(OC_OFF_CYC_P)) oc_cnt_q[k] <= oc_cnt_q[k] + 32'h0000_0001;
    end
  end

  // shutdown policy decode
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_shutdown <= 1'b0;
      o_fast_off <= 1'b0;
      o_por_after <= 1'b0;
      o_power_down <= 1'b0;
    end else begin
      o_shutdown <= i_fault_off || i_host_off || rreq_q || i_key_off ||
        (i_key_long && sdpol_q[BIT_KEY_LONG]) ||
        (i_wdt_timeout && sdpol_q[BIT_WDT_FULL]);
      o_power_down <= i_wdt_timeout && !sdpol_q[BIT_WDT_FULL];
      o_fast_off <= (i_fault_off && sdpol_q[BIT_FAULT_FAST]) ||
        ((i_host_off || rreq_q) && sdpol_q[BIT_HOST_FAST]);
      o_por_after <= (i_key_off || (i_key_long && sdpol_q[BIT_KEY_LONG])) && sdpol_q[BIT_KEY_POR];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) o_serial_reset <= 1'b0;
    else o_serial_reset <= rreq_q && rsttim_q[BIT_IF_RESET];
  end

  // bus stall timeout; any activity restarts the count
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !i_bus_busy || i_bus_activity || !rsttim_q[BIT_BUS_TO]) begin
      to_cnt_q <= 32'h0000_0000;
      o_bus_abort <= 1'b0;
    end else begin
      o_bus_abort <= (to_cnt_q == 32'(BUS_TO_CYC_P - 1));
      if (to_cnt_q < 32'(BUS_TO_CYC_P)) to_cnt_q <= to_cnt_q + 32'h0000_0001;
    end
  end

  // minimum reset mode duration
  always_comb begin
    unique case (rsttim_q[RST_DUR_LSB +: 2])
      2'b00: rst_need = ms_to_cyc(RST_MS_0);
      2'b01: rst_need = ms_to_cyc(RST_MS_1);
      2'b10: rst_need = ms_to_cyc(RST_MS_2);
      2'b11: rst_need = ms_to_cyc(RST_MS_3);
    endcase
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !i_reset_mode) rst_cnt_q <= 32'h0000_0000;
    else if (rst_cnt_q < rst_need) rst_cnt_q <= rst_cnt_q + 32'h0000_0001;
  end
  assign o_reset_min_done = i_reset_mode && (rst_cnt_q >= rst_need);

  // key timing codes; shut delay stacks on the locking threshold
  assign o_key_lock_thr = rsttim_q[KEY_DLY_LSB +: 2];
  assign o_key_off_delay = {1'b0, rsttim_q[KEY_DLY_LSB +: 2]} + {1'b0, rsttim_q[SHUT_DLY_LSB +: 2]};
endmodule : cfg_bank

// *** hdl/cfg_bank_pkg.sv ***
// constants and register map of the customer configuration bank
// Notes on behaviour
// - target address is base nibble then three zeros
// - also answer on base address plus one
// - address field writable only while unlocked
// - high-speed hold keeps interface in high speed
// - fast-plus bit selects fast-mode-plus timing
// - interrupt polarity bit: 0 low, 1 high
// - output type bit: push-pull or open-drain
// - force-reset holds system reset asserted always
// - suppress system-enable load in second read phase
// - interrupt allowed during power-down when enabled
// - auto bucks enabled with A setting at power-up
// - auto linear regulators enabled with A setting
// - switch off regulator after 200 ms overcurrent
// - internal fault shutdown skips sequencer slots
// - host shutdown skips sequencer slots when set
// - key shutdown followed by power-on reset
// - watchdog timeout: full shutdown or power-down
// - long key press triggers shutdown when enabled
// - reset request also resets serial interface
// - abandon serial transfer stalled for 35 ms
// - reset mode lasts 22/100/500/1000 ms minimum
// - key shutdown delay adds onto locking threshold
package cfg_bank_pkg;
  localparam logic [8:0] ADDR_IFACE = 9'h105;
  localparam logic [8:0] ADDR_HOSTPIN = 9'h106;
  localparam logic [8:0] ADDR_FAULTLVL = 9'h107;
  localparam logic [8:0] ADDR_BUCKCLK = 9'h108;
  localparam logic [8:0] ADDR_RSTIRQ = 9'h109;
  localparam logic [8:0] ADDR_BUCKAUTO = 9'h10a;
  localparam logic [8:0] ADDR_LINAUTO = 9'h10c;
  localparam logic [8:0] ADDR_BUCKCUR = 9'h10d;
  localparam logic [8:0] ADDR_SDPOL = 9'h10e;
  localparam logic [8:0] ADDR_RSTTIM = 9'h10f;
  // field positions
  localparam int BIT_HS_HOLD = 6;
  localparam int BIT_FAST_PLUS = 5;
  localparam int BIT_IRQ_POL = 3;
  localparam int BIT_OUT_TYPE = 2;
  localparam int BIT_FORCE_RST = 5;
  localparam int BIT_SYSEN_SUPP = 2;
  localparam int BIT_PD_IRQ = 1;
  localparam int BIT_BUCK1 = 0;
  localparam int BIT_BUCK3 = 2;
  localparam int BIT_BUCK2 = 4;
  localparam int BIT_LIN_OC_OFF = 7;
  localparam int BIT_FAULT_FAST = 6;
  localparam int BIT_HOST_FAST = 5;
  localparam int BIT_KEY_POR = 4;
  localparam int BIT_WDT_FULL = 3;
  localparam int BIT_KEY_LONG = 2;
  localparam int BIT_IF_RESET = 7;
  localparam int BIT_BUS_TO = 6;
  localparam int RST_DUR_LSB = 4;
  localparam int SHUT_DLY_LSB = 2;
  localparam int KEY_DLY_LSB = 0;
  // writable masks: reserved read-only bit 7 of host pin register
  localparam logic [7:0] MASK_HOSTPIN = 8'h7f;
  localparam logic [7:0] MASK_IFACE = 8'hf0;
  // reset values standing in for nonvolatile load
  localparam logic [7:0] RST_IFACE = 8'hb0;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int OC_OFF_MS = 200;
  localparam int BUS_TO_MS = 35;
  localparam int RST_MS_0 = 22;
  localparam int RST_MS_1 = 100;
  localparam int RST_MS_2 = 500;
  localparam int RST_MS_3 = 1000;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int OC_OFF_CYC = OC_OFF_MS * CYC_PER_MS;
  localparam int BUS_TO_CYC = BUS_TO_MS * CYC_PER_MS;
endpackage : cfg_bank_pkg

// *** bench/cfg_bank_assertions.sv ***
// port-level checks of the configuration bank
`timescale 1ns/1ns
module cfg_bank_checker (
  input wire logic i_ref_clk, i_srst, i_wr_en, i_application_lock_fuse, // clock, reset, strobe
  input wire logic i_irq_req, i_low_power_down_state, i_second_nvm_read_phase, // levels
  input wire logic i_wdt_timeout, i_power_up, // event pulses
  input wire logic [8:0] i_addr, // register address
  input wire logic [6:0] i_bus_addr, // serial address
  input wire logic [7:0] o_rdata, // read data
  input wire logic o_addr_match, o_serial_high_speed_hold, o_serial_fast_plus_sel, // flags
  input wire logic o_interrupt_out_pin_o, o_interrupt_out_pin_oe_n, o_system_reset_out_pin_o, // pins
  input wire logic o_sysen_load_en, o_shutdown, o_power_down, // policy
  input wire logic [2:0] o_buck_en // buck enables
);
  import cfg_bank_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  // read port parked on a register, no write landing that could move it
  logic on_pin;
  logic on_rst;
  assign on_pin = i_addr == ADDR_HOSTPIN && !i_wr_en;
  assign on_rst = i_addr == ADDR_RSTIRQ && !i_wr_en;
  sequence s_irq_pp;
    on_pin && !o_rdata[BIT_OUT_TYPE] && i_irq_req && !i_low_power_down_state;
  endsequence
  sequence s_wdt;
    i_wdt_timeout && i_addr == ADDR_SDPOL && !i_wr_en;
  endsequence
  sequence s_pwr;
    i_power_up && i_addr == ADDR_BUCKAUTO && !i_wr_en;
  endsequence
  addr_match_a: assert property (i_addr == ADDR_IFACE |->
    o_addr_match == (i_bus_addr[6:1] == {o_rdata[7:4], 2'b00})) else $error("target address match wrong");
  lock_hold_a: assert property (i_addr == ADDR_IFACE &&
    $past(i_addr == ADDR_IFACE && i_wr_en && i_application_lock_fuse) |-> o_rdata == $past(o_rdata))
    else $error("locked address field changed");
  speed_bits_a: assert property (i_addr == ADDR_HOSTPIN |->
    {o_serial_high_speed_hold, o_serial_fast_plus_sel} == o_rdata[6:5]) else $error("speed mode flags wrong");
  irq_pol_a: assert property (s_irq_pp |=>
    o_interrupt_out_pin_o == $past(o_rdata[BIT_IRQ_POL]) && !o_interrupt_out_pin_oe_n) else $error("irq level wrong");
  od_release_a: assert property (on_pin && o_rdata[3:2] == 2'b01 && !i_irq_req |=>
    o_interrupt_out_pin_oe_n) else $error("open-drain irq not released");
  force_rst_a: assert property (on_rst && o_rdata[BIT_FORCE_RST] |=>
    !o_system_reset_out_pin_o) else $error("forced reset not held");
  sysen_gate_a: assert property (on_rst && o_rdata[BIT_SYSEN_SUPP] && i_second_nvm_read_phase |->
    !o_sysen_load_en) else $error("system-enable load not suppressed");
  wdt_policy_a: assert property (s_wdt |=>
    {o_shutdown, o_power_down} == {$past(o_rdata[3]), !$past(o_rdata[3])}) else $error("watchdog action wrong");
  power_up_a: assert property (s_pwr |=>
    o_buck_en == {$past(o_rdata[2]), $past(o_rdata[4]), $past(o_rdata[0])}) else $error("buck autostart wrong");
endmodule : cfg_bank_checker
bind cfg_bank cfg_bank_checker chk (.i_ref_clk, .i_srst, .i_wr_en, .i_application_lock_fuse, .i_irq_req,
  .i_low_power_down_state, .i_second_nvm_read_phase, .i_wdt_timeout, .i_power_up, .i_addr, .i_bus_addr,
  .o_rdata, .o_addr_match, .o_serial_high_speed_hold, .o_serial_fast_plus_sel, .o_interrupt_out_pin_o,
  .o_interrupt_out_pin_oe_n, .o_system_reset_out_pin_o, .o_sysen_load_en, .o_shutdown, .o_power_down,
  .o_buck_en);

// *** bench/host_model.sv ***
// host side of the register path: writes and read-backs
`timescale 1ns/1ns
module host_model (
  input wire logic i_clk, // core clock
  input wire logic [7:0] i_rdata, // read data
  output logic o_wr_en = 1'b0, // write strobe
  output logic [8:0] o_addr = 9'h000, // register address
  output logic [7:0] o_wdata = 8'h00 // write data
);
  // one-cycle strobe; address stays parked for the read port
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_wdata = ~d; // stale data is not left looking valid
  endtask : wr
  // read port is combinational, sampled a full cycle later
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    @(negedge i_clk);
    d = i_rdata;
  endtask : rd
endmodule : host_model

// *** bench/testbench.sv ***
// self-checking bench for the configuration bank
`timescale 1ns/1ns
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
  import cfg_bank_pkg::*;
  logic clk = 0, srst = 1, lock = 0, irq = 0, pdn = 0, nvm2 = 0, pwr = 0, wdt = 0, f_off = 0, h_off = 0;
  logic k_off = 0, k_long = 0, busy = 0, rmode = 0, seq_rst = 0, act = 0, rreq_n = 1, abort, rdone, sd, fast, por, pdwn;
  logic [3:0] oc = 4'h0;
  logic match, hs, fp, irq_o, irq_oe_n, rst_o, rst_oe_n, sysen, wr_en, srs;
  logic [6:0] bus_a = 0;
  logic [8:0] addr;
  logic [7:0] wdata, rdata, rd_v;
  logic [3:0] lin_en, lin_a;
  logic [2:0] buck_en, buck_a, kdly;
  logic [1:0] thr;
  int bad_count = 0, checked = 0, cyc = 0, n;
  always #4 clk = ~clk;
  host_model host (.i_clk(clk), .i_rdata(rdata), .o_wr_en(wr_en), .o_addr(addr), .o_wdata(wdata));
  cfg_bank #(.OC_OFF_CYC_P(20), .BUS_TO_CYC_P(20), .CYC_PER_MS_P(10)) uut (.i_ref_clk(clk), .i_srst(srst),
    .i_wr_en(wr_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_application_lock_fuse(lock),
    .i_bus_addr(bus_a), .o_addr_match(match), .o_serial_high_speed_hold(hs), .o_serial_fast_plus_sel(fp),
    .i_irq_req(irq), .i_low_power_down_state(pdn), .o_interrupt_out_pin_o(irq_o), .o_interrupt_out_pin_oe_n(irq_oe_n),
    .i_seq_reset_req(seq_rst), .o_system_reset_out_pin_o(rst_o), .o_system_reset_out_pin_oe_n(rst_oe_n),
    .i_second_nvm_read_phase(nvm2), .o_sysen_load_en(sysen), .i_power_up(pwr), .o_buck_en(buck_en),
    .o_buck_sel_a(buck_a), .o_linreg_en(lin_en), .o_linreg_sel_a(lin_a), .i_linreg_oc(oc), .i_fault_off(f_off),
    .i_host_off(h_off), .i_host_reset_request_pin(rreq_n), .i_key_off(k_off), .i_key_long(k_long),
    .i_wdt_timeout(wdt), .o_shutdown(sd), .o_fast_off(fast), .o_por_after(por), .o_power_down(pdwn),
    .o_serial_reset(srs), .i_bus_busy(busy), .i_bus_activity(act), .o_bus_abort(abort), .i_reset_mode(rmode),
    .o_reset_min_done(rdone), .o_key_lock_thr(thr), .o_key_off_delay(kdly));
  task automatic report_and_stop;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // reset values, lock, address decode, reserved bit
  task automatic t_regs;
    host.rd(ADDR_IFACE, rd_v);
    `CHK("iface reset", 8'hb0, rd_v)
    host.rd(9'h10b, rd_v);
    `CHK("unmapped", 8'h00, rd_v)
    lock = 1;
    host.wr(ADDR_IFACE, 8'h5a);
    `CHK("locked", 8'hb0, rdata)
    lock = 0;
    host.wr(ADDR_IFACE, 8'ha5);
    `CHK("unlocked", 8'ha0, rdata)
    for (int k = 0; k < 3; k++) begin
      bus_a = 7'h50 + 7'(k);
      #1 `CHK("match", 1'(k < 2), match)
    end
    host.wr(ADDR_HOSTPIN, 8'hff);
    `CHK("pin cfg", 8'h7f, rdata)
    `CHK("speed", 2'b11, {hs, fp})
  endtask : t_regs
  // pin polarity, driver type, forced reset, load gate, power-down irq
  task automatic t_pins;
    irq = 1;
    host.wr(ADDR_HOSTPIN, 8'h00);
    @(negedge clk) `CHK("irq lo", 2'b00, {irq_o, irq_oe_n})
    host.wr(ADDR_HOSTPIN, 8'h08);
    @(negedge clk) `CHK("irq hi", 2'b10, {irq_o, irq_oe_n})
    host.wr(ADDR_HOSTPIN, 8'h04);
    irq = 0;
    @(negedge clk) `CHK("od idle", 2'b11, {irq_oe_n, rst_oe_n})
    host.wr(ADDR_RSTIRQ, 8'h20);
    @(negedge clk) `CHK("force", 2'b00, {rst_o, rst_oe_n})
    nvm2 = 1;
    host.wr(ADDR_RSTIRQ, 8'h04);
    `CHK("sysen off", 1'b0, sysen)
    host.wr(ADDR_RSTIRQ, 8'h00);
    `CHK("sysen on", 1'b1, sysen)
    seq_rst = 1;
    @(negedge clk) `CHK("seq rst", 2'b00, {rst_o, rst_oe_n})
    seq_rst = 0;
    @(negedge clk) `CHK("seq idle", 2'b11, {rst_o, rst_oe_n})
    host.wr(ADDR_HOSTPIN, 8'h00);
    {pdn, irq} = 2'b11;
    @(negedge clk) `CHK("pd quiet", 1'b1, irq_o)
    host.wr(ADDR_RSTIRQ, 8'h02);
    @(negedge clk) `CHK("pd irq", 1'b0, irq_o)
    {pdn, irq} = 2'b00;
  endtask : t_pins
  task automatic t_power;
    host.wr(ADDR_LINAUTO, 8'h09);
    host.wr(ADDR_BUCKAUTO, 8'h11);
    pwr = 1;
    @(negedge clk) pwr = 0;
    @(negedge clk) `CHK("buck", 6'h1b, {buck_en, buck_a})
    `CHK("linreg", 8'h99, {lin_en, lin_a})
    // overcurrent on regulator one: 3-stage sync, then 20-cycle persistence
    host.wr(ADDR_SDPOL, 8'h80);
    oc = 4'h1;
    for (n = 0; lin_en[0] !== 1'b0 && n < 100; n++) @(negedge clk);
    oc = 4'h0;
    `CHK("oc off time", 1'b1, 1'(n >= 24 && n <= 27))
    `CHK("oc others", 4'h8, lin_en)
  endtask : t_power
  // request pin low: synchronised, then shutdown with fast path and serial reset
  task automatic t_rreq;
    host.wr(ADDR_SDPOL, 8'h20);
    host.wr(ADDR_RSTTIM, 8'h80);
    rreq_n = 0;
    for (n = 0; srs !== 1'b1 && n < 20; n++) @(negedge clk);
    `CHK("rreq delay", 1'b1, 1'(n >= 4 && n <= 6))
    `CHK("rreq off", 2'b11, {sd, fast})
    rreq_n = 1;
    repeat (8) @(negedge clk);
    `CHK("rreq idle", 1'b0, srs)
  endtask : t_rreq
  // one policy write, one event pulse, outputs {shutdown, fast, por, power-down}
  task automatic hit(input logic [7:0] v, input int k, input logic [3:0] e);
    host.wr(ADDR_SDPOL, v);
    {wdt, f_off, h_off, k_off, k_long} = 5'(1 << k);
    @(negedge clk) {wdt, f_off, h_off, k_off, k_long} = 5'h00;
    `CHK("policy", e, {sd, fast, por, pdwn})
  endtask : hit
  task automatic t_timing;
    host.wr(ADDR_RSTTIM, 8'h4e);
    `CHK("key codes", 5'h15, {thr, kdly})
    busy = 1;
    repeat (10) @(negedge clk);
    // activity restarts the stall count
    act = 1;
    @(negedge clk) act = 0;
    for (n = 0; abort !== 1'b1 && n < 100; n++) @(negedge clk);
    busy = 0;
    `CHK("abort", 1'b1, 1'(n >= 20 && n <= 23))
    for (int c = 0; c < 2; c++) begin
      host.wr(ADDR_RSTTIM, 8'(c << 4));
      rmode = 1;
      for (n = 0; rdone !== 1'b1 && n < 2000; n++) @(negedge clk);
      rmode = 0;
      `CHK("reset len", 1'b1, 1'(n >= (c ? 1000 : 220) && n <= (c ? 1004 : 224)))
      @(negedge clk);
    end
  endtask : t_timing
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    srst = 0;
    t_regs;
    t_pins;
    t_power;
    hit(8'h00, 4, 4'b0001);
    hit(8'h08, 4, 4'b1000);
    hit(8'h40, 3, 4'b1100);
    hit(8'h00, 3, 4'b1000);
    hit(8'h20, 2, 4'b1100);
    hit(8'h10, 1, 4'b1010);
    hit(8'h04, 0, 4'b1000);
    hit(8'h00, 0, 4'b0000);
    t_rreq;
    t_timing;
    report_and_stop;
  end
endmodule : testbench
